// [rtl/sra_pkg.sv]
package sra_pkg;

  localparam int CLK_HZ        = 20_000_000;
  localparam int PROG_TIME_US  = 350;
  localparam int ERASE_TIME_MS = 20;
  localparam int PROG_CYC      = (PROG_TIME_US * (CLK_HZ / 1_000_000) > 0) ?
                                 PROG_TIME_US * (CLK_HZ / 1_000_000) : 1;
  localparam int ERASE_CYC     = (ERASE_TIME_MS * (CLK_HZ / 1_000) > 0) ?
                                 ERASE_TIME_MS * (CLK_HZ / 1_000) : 1;
  localparam int CNT_W         = 20;

  localparam logic [7:0] CMD_NV_LO  = 8'h80;
  localparam logic [7:0] CMD_NV_HI  = 8'h81;
  localparam logic [7:0] CMD_BLK_WR = 8'hA0;
  localparam logic [7:0] CMD_BLK_RD = 8'hA1;
  localparam logic [7:0] CMD_ERASE  = 8'hA2;
  localparam logic [7:0] VOL_HI     = 8'h00;
  localparam logic [7:0] VOL_TOP    = 8'h7F;
  localparam logic [7:0] NV_LO_LIM  = 8'hFF;
  localparam logic [7:0] NV_HI_LIM  = 8'h3F;
  localparam logic [7:0] ERASED     = 8'hFF;
  localparam logic [4:0] PAGE_LAST  = 5'h1F;
  localparam logic [5:0] IDX_SAT    = 6'h3F;

  localparam int RAM_DEPTH = 128;
  localparam int NV_AW     = 9;
  localparam int PAGE_SIZE = 32;
  localparam int BLK_MAX   = 32;
  localparam int BUF_DEPTH = 2;

endpackage : sra_pkg

// [rtl/sra_pair_buf.sv]
`timescale 1ns/1ps
module sra_pair_buf #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  import sra_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_check
    $error("sra_pair_buf: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } sra_buf_type;

  sra_buf_type      r;
  sra_buf_type      n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             doPush;
  logic             doPop;

  assign inReady  = r.cnt != (AW+1)'(DEPTH);
  assign outValid = r.cnt != '0;
  assign outData  = mem[r.rp];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_comb
  begin
    n = r;
    if (doPush)
    begin
      n.wp = r.wp + 1'b1;
    end
    if (doPop)
    begin
      n.rp = r.rp + 1'b1;
    end
    if (doPush && !doPop)
    begin
      n.cnt = r.cnt + 1'b1;
    end
    else if (doPop && !doPush)
    begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  // storage carries no reset; only the count defines validity
  always_ff @(posedge clk)
  begin
    if (doPush)
    begin
      mem[r.wp] <= inData;
    end
  end

endmodule : sra_pair_buf

// [rtl/sra_core.sv]
`timescale 1ns/1ps
module sra_core #(
  parameter int PROG_CYCLES  = sra_pkg::PROG_CYC,
  parameter int ERASE_CYCLES = sra_pkg::ERASE_CYC,
  parameter int BLK_RD_LEN   = sra_pkg::BLK_MAX
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // bus clock, open drain
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  // bus data, open drain
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // slave address and status
  input  wire logic [6:0] slaveAddr,
  output logic            nvBusy
);
  import sra_pkg::*;

  if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << CNT_W) || ERASE_CYCLES <= PAGE_SIZE ||
      ERASE_CYCLES >= (1 << CNT_W) || BLK_RD_LEN < 1 || BLK_RD_LEN > 255)
  begin : g_check
    $error("sra_core: timing or block length parameter out of range");
  end

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_RX   = 6'b00_0010,
    ST_DEC  = 6'b00_0100,
    ST_ACK  = 6'b00_1000,
    ST_TX   = 6'b01_0000,
    ST_MACK = 6'b10_0000
  } sra_state_type;

  typedef struct packed {
    sra_state_type    st;
    logic             sclPrev;
    logic             sdaPrev;
    logic [3:0]       bitCnt;
    logic [7:0]       shift;
    logic             rw;
    logic [5:0]       byteIdx;
    logic [7:0]       cmd;
    logic [7:0]       lowAddr;
    logic [15:0]      ptr;
    logic             stuck;
    logic [7:0]       blkCnt;
    logic             blkArm;
    logic [7:0]       txShift;
    logic [CNT_W-1:0] erCnt;
    logic [3:0]       erPage;
    logic [CNT_W-1:0] progCnt;
    logic [NV_AW-1:0] progAddr;
    logic [7:0]       progData;
    logic             sclOe;
    logic             sdaOe;
    logic             sdaOut;
    logic             busy;
  } sra_core_type;

  sra_core_type     r;
  sra_core_type     n;
  logic [7:0]       ram [RAM_DEPTH];
  logic [7:0]       nv  [1 << NV_AW];
  logic             ramWe;
  logic [6:0]       ramWa;
  logic [7:0]       ramWd;
  logic             nvWe;
  logic [NV_AW-1:0] nvWa;
  logic [7:0]       nvWd;
  logic             pushValid;
  logic [16:0]      pushData;
  logic             pushReady;
  logic             popValid;
  logic [16:0]      popData;
  logic             popReady;
  logic             sclRise;
  logic             sclFall;
  logic             startSeen;
  logic             stopSeen;
  logic             busyNow;

  // pointer space decode: high byte 00h volatile, 80h/81h nonvolatile
  function automatic logic isNv(input logic [15:0] p);
    isNv = (p[15:8] == CMD_NV_LO) || (p[15:8] == CMD_NV_HI);
  endfunction : isNv

  function automatic logic nvOk(input logic [15:0] p, input logic stk);
    nvOk = !stk && ((p[15:8] == CMD_NV_LO) ||
                    (p[15:8] == CMD_NV_HI && p[7:0] <= NV_HI_LIM));
  endfunction : nvOk

  function automatic logic volOk(input logic [15:0] p);
    volOk = (p[15:8] == VOL_HI) && (p[7:0] <= VOL_TOP);
  endfunction : volOk

  // returns {stuck, pointer}; nonvolatile limits freeze the pointer
  function automatic logic [16:0] nextPtr(input logic [15:0] p, input logic stk);
    logic atLim;
    atLim = (p[15:8] == CMD_NV_LO && p[7:0] == NV_LO_LIM) ||
            (p[15:8] == CMD_NV_HI && p[7:0] >= NV_HI_LIM);
    if (stk || atLim)
    begin
      nextPtr = {1'b1, p};
    end
    else if (p[7:0] == NV_LO_LIM)
    begin
      nextPtr = {1'b0, p};
    end
    else
    begin
      nextPtr = {1'b0, p[15:8], p[7:0] + 8'h01};
    end
  endfunction : nextPtr

  function automatic logic [7:0] readAt(input logic [15:0] p, input logic stk);
    if (volOk(p))
    begin
      readAt = ram[p[6:0]];
    end
    else if (isNv(p) && nvOk(p, stk))
    begin
      readAt = nv[{p[8], p[7:0]}];
    end
    else
    begin
      readAt = '0;
    end
  endfunction : readAt

  assign sclRise   = sclIn && !r.sclPrev;
  assign sclFall   = !sclIn && r.sclPrev;
  assign startSeen = sclIn && r.sclPrev && r.sdaPrev && !sdaIn;
  assign stopSeen  = sclIn && r.sclPrev && !r.sdaPrev && sdaIn;
  assign busyNow   = (r.erCnt != '0) || (r.progCnt != '0) || popValid;

  // queued programming absorbs a stall without losing the byte
  sra_pair_buf #(
    .WIDTH (17),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inValid  (pushValid),
    .inData   (pushData),
    .inReady  (pushReady),
    .outValid (popValid),
    .outData  (popData),
    .outReady (popReady)
  );

  always_comb
  begin
    logic [16:0] np;
    logic [7:0]  txByte;
    logic [5:0]  k;
    logic        needPush;
    logic        nack;
    logic        nvCmd;
    np        = '0;
    txByte    = '0;
    k         = r.byteIdx - 6'd2;
    needPush  = 1'b0;
    nack      = 1'b0;
    nvCmd     = 1'b0;
    n         = r;
    n.sclPrev = sclIn;
    n.sdaPrev = sdaIn;
    n.busy    = busyNow;
    n.sdaOut  = 1'b0;
    ramWe     = 1'b0;
    ramWa     = '0;
    ramWd     = '0;
    nvWe      = 1'b0;
    nvWa      = '0;
    nvWd      = '0;
    pushValid = 1'b0;
    pushData  = '0;
    popReady  = 1'b0;

    // erase and programming engines; erase fills the page near its end
    if (r.erCnt != '0)
    begin
      n.erCnt = r.erCnt - 1'b1;
      if (r.erCnt <= CNT_W'(PAGE_SIZE))
      begin
        nvWe = 1'b1;
        nvWa = {r.erPage, 5'(r.erCnt - 1'b1)};
        nvWd = ERASED;
      end
    end
    else if (r.progCnt != '0)
    begin
      n.progCnt = r.progCnt - 1'b1;
      if (r.progCnt == CNT_W'(1))
      begin
        nvWe = 1'b1;
        nvWa = r.progAddr;
        // programming only clears bits; erased cells read all ones
        nvWd = nv[r.progAddr] & r.progData;
      end
    end
    else if (popValid)
    begin
      popReady   = 1'b1;
      n.progAddr = popData[16:8];
      n.progData = popData[7:0];
      n.progCnt  = CNT_W'(PROG_CYCLES);
    end

    if (startSeen)
    begin
      // a repeated start keeps pointer and block-read arming
      n.st      = ST_RX;
      n.bitCnt  = '0;
      n.byteIdx = '0;
      n.sdaOe   = 1'b0;
      n.sclOe   = 1'b0;
    end
    else if (stopSeen)
    begin
      n.st     = ST_IDLE;
      n.blkArm = 1'b0;
      n.sdaOe  = 1'b0;
      n.sclOe  = 1'b0;
    end
    else
    begin
      unique case (r.st)
        ST_IDLE:
        begin
          n.sdaOe = 1'b0;
        end
        ST_RX:
        begin
          if (sclRise)
          begin
            n.shift  = {r.shift[6:0], sdaIn};
            n.bitCnt = r.bitCnt + 4'd1;
          end
          else if (sclFall && r.bitCnt == 4'd8)
          begin
            n.st = ST_DEC;
          end
        end
        ST_DEC:
        begin
          if (r.byteIdx == 6'd0)
          begin
            n.rw = r.shift[0];
            if (r.shift[7:1] != slaveAddr)
            begin
              nack = 1'b1;
            end
            else if (r.shift[0] && isNv(r.ptr) && busyNow)
            begin
              nack = 1'b1;
            end
          end
          else if (r.byteIdx == 6'd1)
          begin
            // the command value picks what follows; for a block write the pointer space also decides the busy refusal
            n.cmd    = r.shift;
            n.blkArm = (r.shift == CMD_BLK_RD);
            n.blkCnt = '0;
            nvCmd    = (r.shift == CMD_NV_LO) || (r.shift == CMD_NV_HI) ||
                       (r.shift == CMD_ERASE) || (r.shift == CMD_BLK_WR && isNv(r.ptr));
            if (nvCmd && busyNow)
            begin
              nack = 1'b1;
            end
            else if (!r.shift[7])
            begin
              n.ptr   = {VOL_HI, r.shift};
              n.stuck = 1'b0;
            end
          end
          else if (!r.cmd[7])
          begin
            if (k == 6'd0)
            begin
              ramWe = 1'b1;
              ramWa = r.cmd[6:0];
              ramWd = r.shift;
            end
          end
          else if (r.cmd == CMD_NV_LO || r.cmd == CMD_NV_HI)
          begin
            if (k == 6'd0)
            begin
              n.lowAddr = r.shift;
              n.ptr     = {r.cmd, r.shift};
              n.stuck   = 1'b0;
            end
            else if (k == 6'd1 && nvOk({r.cmd, r.lowAddr}, 1'b0))
            begin
              needPush = 1'b1;
              pushData = {r.cmd[0], r.lowAddr, r.shift};
            end
          end
          else if (r.cmd == CMD_BLK_WR)
          begin
            if (k == 6'd0)
            begin
              n.blkCnt = r.shift;
            end
            else if ({2'b00, k} <= r.blkCnt)
            begin
              if (volOk(r.ptr) && !r.stuck)
              begin
                ramWe = 1'b1;
                ramWa = r.ptr[6:0];
                ramWd = r.shift;
              end
              else if (isNv(r.ptr) && nvOk(r.ptr, r.stuck))
              begin
                needPush = 1'b1;
                pushData = {r.ptr[8], r.ptr[7:0], r.shift};
              end
            end
          end
          else if (r.cmd == CMD_ERASE && k == 6'd0)
          begin
            n.erPage = {r.ptr[15:8] == CMD_NV_HI, r.shift[7:5]};
            n.erCnt  = CNT_W'(ERASE_CYCLES);
          end

          // stretch the clock while the queue is full
          if (needPush && !pushReady)
          begin
            n       = r;
            n.sclPrev = sclIn;
            n.sdaPrev = sdaIn;
            n.busy    = busyNow;
            n.erCnt   = (r.erCnt != '0) ? r.erCnt - 1'b1 : r.erCnt;
            n.progCnt = (r.erCnt == '0 && r.progCnt != '0) ? r.progCnt - 1'b1 : r.progCnt;
            if (r.erCnt == '0 && r.progCnt == '0 && popValid)
            begin
              n.progAddr = popData[16:8];
              n.progData = popData[7:0];
              n.progCnt  = CNT_W'(PROG_CYCLES);
            end
            n.sclOe = 1'b1;
            ramWe   = 1'b0;
          end
          else
          begin
            pushValid = needPush;
            // a stretch is let go one cycle after the ack is driven, so sda is set up before scl rises
            n.sclOe   = r.sclOe && !nack;
            n.byteIdx = r.byteIdx + {5'd0, r.byteIdx != IDX_SAT};
            if (r.cmd == CMD_BLK_WR && r.byteIdx >= 6'd3 && {2'b00, k} <= r.blkCnt)
            begin
              np      = nextPtr(r.ptr, r.stuck);
              n.ptr   = np[15:0];
              // nonvolatile block writes never run past the page end
              n.stuck = np[16] || (isNv(r.ptr) && r.ptr[4:0] == PAGE_LAST);
            end
            if (nack)
            begin
              n.st    = ST_IDLE;
              n.sdaOe = 1'b0;
            end
            else
            begin
              n.st    = ST_ACK;
              n.sdaOe = 1'b1;
            end
          end
        end
        ST_ACK:
        begin
          n.sclOe = 1'b0;
          if (sclFall)
          begin
            n.bitCnt = '0;
            n.sdaOe  = 1'b0;
            if (r.rw)
            begin
              if (r.blkArm && r.byteIdx == 6'd1)
              begin
                txByte = 8'(BLK_RD_LEN);
              end
              else
              begin
                txByte = readAt(r.ptr, r.stuck);
                if (r.blkArm)
                begin
                  np      = nextPtr(r.ptr, r.stuck);
                  n.ptr   = np[15:0];
                  n.stuck = np[16];
                end
              end
              n.sdaOe   = !txByte[7];
              n.txShift = {txByte[6:0], 1'b0};
              n.byteIdx = r.byteIdx + {5'd0, r.byteIdx != IDX_SAT};
              n.st      = ST_TX;
            end
            else
            begin
              n.st = ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (sclRise)
          begin
            n.bitCnt = r.bitCnt + 4'd1;
          end
          else if (sclFall)
          begin
            if (r.bitCnt == 4'd8)
            begin
              n.sdaOe = 1'b0;
              n.st    = ST_MACK;
            end
            else
            begin
              n.sdaOe   = !r.txShift[7];
              n.txShift = {r.txShift[6:0], 1'b0};
            end
          end
        end
        ST_MACK:
        begin
          if (sclRise)
          begin
            // a master NACK ends the read; the stop follows
            n.st = sdaIn ? ST_IDLE : ST_ACK;
          end
        end
        default:
        begin
          n.st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r         <= '0;
      r.st      <= ST_IDLE;
      r.sclPrev <= 1'b1;
      r.sdaPrev <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // arrays hold no reset; power-up contents are loaded elsewhere
  always_ff @(posedge clk)
  begin
    if (ramWe)
    begin
      ram[ramWa] <= ramWd;
    end
    if (nvWe)
    begin
      nv[nvWa] <= nvWd;
    end
  end

  assign sclOut = 1'b0;
  assign sclOe  = r.sclOe;
  assign sdaOut = r.sdaOut;
  assign sdaOe  = r.sdaOe;
  assign nvBusy = r.busy;

endmodule : sra_core

// [verification/sra_core_props.sv]
`timescale 1ns/1ps
module sra_core_props #(
  parameter int PROG_CYCLES  = 20,
  parameter int ERASE_CYCLES = 40
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // bus clock
  input wire logic       sclIn,
  input wire logic       sclOut,
  input wire logic       sclOe,
  // bus data
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  // address and status
  input wire logic [6:0] slaveAddr,
  input wire logic       nvBusy
);
  // a full 32-byte page may keep the programmer busy back to back
  localparam int BUSY_MAX = ERASE_CYCLES + 33 * PROG_CYCLES + 64;
  typedef struct packed {
    logic        sclPrev;
    logic [15:0] sinceFall;
    logic [15:0] stretchCnt;
    logic [15:0] busyCnt;
  } sra_chk_type;
  sra_chk_type chkReg;
  sra_chk_type chkNext;
  logic        fallNow;

  function automatic logic [15:0] sat(input logic [15:0] v);
    return v + {15'h0000, ~&v};
  endfunction : sat

  assign fallNow = chkReg.sclPrev & ~sclIn;

  always_comb
  begin
    chkNext            = chkReg;
    chkNext.sclPrev    = sclIn;
    // a stretch restarts the low phase, so it counts as a fresh fall
    chkNext.sinceFall  = (fallNow || sclOe) ? 16'h0000 : sat(chkReg.sinceFall);
    chkNext.stretchCnt = sclOe ? sat(chkReg.stretchCnt) : 16'h0000;
    chkNext.busyCnt    = nvBusy ? sat(chkReg.busyCnt) : 16'h0000;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      chkReg <= '{1'b1, 16'hFFFF, 16'h0000, 16'h0000};
    else
      chkReg <= chkNext;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence startSeen;
    sclIn && $past(sclIn) && $fell(sdaIn);
  endsequence
  sequence stopSeen;
    sclIn && $past(sclIn) && $rose(sdaIn);
  endsequence

  a_scl_out_zero: assert property (sclOut == 1'b0)
    else $error("scl output level not low");
  a_sda_out_zero: assert property (sdaOut == 1'b0)
    else $error("sda output level not low");
  a_sda_hold_high: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("sda drive changed while scl high");
  a_sda_near_fall: assert property ($changed(sdaOe) |-> chkReg.sinceFall <= 16'h0006)
    else $error("sda drive changed far from scl fall");
  a_start_quiet: assert property (startSeen |=> !sdaOe [*8])
    else $error("sda driven right after start");
  a_stop_quiet: assert property (stopSeen |=> !sdaOe [*8])
    else $error("sda driven right after stop");
  a_stretch_needs_busy: assert property (sclOe |-> nvBusy)
    else $error("clock stretched while programmer idle");
  a_stretch_bound: assert property (chkReg.stretchCnt <= 16'(2 * PROG_CYCLES + 16))
    else $error("clock stretch too long");
  a_busy_bound: assert property (chkReg.busyCnt <= 16'(BUSY_MAX))
    else $error("busy flag held too long");
endmodule : sra_core_props

// [verification/sra_host_model.sv]
`timescale 1ns/1ps
module sra_host_model (
  // clock
  input  wire logic clk,
  // device pull-downs
  input  wire logic sclOe,
  input  wire logic sdaOe,
  // wire levels
  output logic      sclIn,
  output logic      sdaIn
);
  logic sclDrv      = 1'b1;
  logic sdaDrv      = 1'b1;
  int   stretchSeen = 0;
  // pull-ups: a line is low when either side pulls it
  assign sclIn = sclDrv & ~sclOe;
  assign sdaIn = sdaDrv & ~sdaOe;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  // data changes one cycle into the low phase and stands over the whole high phase
  task automatic pulse(input logic bitOut, output logic bitIn);
    int n;
    n = 0;
    tick(1);
    sdaDrv = bitOut;
    tick(6);
    sclDrv = 1'b1;
    tick(1);
    while (!sclIn && n < 2000)
    begin
      stretchSeen++;
      n++;
      tick(1);
    end
    if (!sclIn)
    begin
      tb.errTotal++;
      tb.endSim();
    end
    tick(6);
    bitIn  = sdaIn;
    sclDrv = 1'b0;
  endtask : pulse

  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      pulse(d[i], b);
    pulse(1'b1, b);
    ack = ~b;
  endtask : wrByte

  task automatic rdByte(input logic ackOut, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(1'b1, b);
      d[i] = b;
    end
    pulse(~ackOut, b);
  endtask : rdByte

  // also serves as repeated start from the low phase
  task automatic startCond;
    tick(1);
    sdaDrv = 1'b1;
    tick(4);
    sclDrv = 1'b1;
    tick(6);
    sdaDrv = 1'b0;
    tick(6);
    sclDrv = 1'b0;
  endtask : startCond

  task automatic stopCond;
    tick(1);
    sdaDrv = 1'b0;
    tick(4);
    sclDrv = 1'b1;
    tick(6);
    sdaDrv = 1'b1;
    tick(10);
  endtask : stopCond
endmodule : sra_host_model

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam int         PROG_TB  = 600;
  localparam int         ERASE_TB = 2000;
  localparam int         BLK_TB   = 4;
  localparam logic [7:0] BLK_CNT  = 8'(BLK_TB);
  // arbitrary bus address
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  logic       clk;
  logic       sys_rst;
  logic       sclIn;
  logic       sclOe;
  logic       sdaIn;
  logic       sdaOe;
  logic [6:0] slaveAddr;
  logic       nvBusy;
  int         errTotal = 0;
  int         checked  = 0;

  sra_core #(.PROG_CYCLES(PROG_TB), .ERASE_CYCLES(ERASE_TB), .BLK_RD_LEN(BLK_TB)) u_sra_core (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .sclIn    (sclIn),
    .sclOut   (),
    .sclOe    (sclOe),
    .sdaIn    (sdaIn),
    .sdaOut   (),
    .sdaOe    (sdaOe),
    .slaveAddr(slaveAddr),
    .nvBusy   (nvBusy)
  );
  sra_host_model u_sra_host_model (
    .clk  (clk),
    .sclOe(sclOe),
    .sdaOe(sdaOe),
    .sclIn(sclIn),
    .sdaIn(sdaIn)
  );

  task automatic endSim;
    if (errTotal == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : endSim

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      errTotal++;
    end
  endtask : chk

  task automatic wrTxn(input logic [7:0] bytes[$], input logic expLast, input logic doStop);
    logic ack;
    u_sra_host_model.startCond();
    u_sra_host_model.wrByte({DEV_ADDR, 1'b0}, ack);
    chk("write address ack", 8'h01, {7'h00, ack});
    foreach (bytes[i])
    begin
      u_sra_host_model.wrByte(bytes[i], ack);
      chk("byte ack", (i == bytes.size() - 1) ? {7'h00, expLast} : 8'h01, {7'h00, ack});
    end
    if (doStop)
      u_sra_host_model.stopCond();
  endtask : wrTxn

  task automatic rdChk(input logic [7:0] exp[$]);
    logic       ack;
    logic [7:0] got;
    u_sra_host_model.startCond();
    u_sra_host_model.wrByte({DEV_ADDR, 1'b1}, ack);
    chk("read address ack", 8'h01, {7'h00, ack});
    foreach (exp[i])
    begin
      u_sra_host_model.rdByte(i < exp.size() - 1, got);
      chk("read data", exp[i], got);
    end
    u_sra_host_model.stopCond();
  endtask : rdChk

  task automatic waitIdle;
    int n;
    n = 0;
    while (nvBusy !== 1'b0 && n < 30000)
    begin
      @(posedge clk);
      #2;
      n++;
    end
    if (nvBusy !== 1'b0)
    begin
      $display("ERROR nvBusy expected 0 seen %b", nvBusy);
      errTotal++;
      endSim();
    end
  endtask : waitIdle

  task automatic sRamByte;
    logic ack;
    wrTxn({8'h10, 8'h05}, 1'b1, 1'b1);
    // another device's address must be left unanswered
    u_sra_host_model.startCond();
    u_sra_host_model.wrByte({DEV_ADDR ^ 7'h01, 1'b0}, ack);
    chk("foreign address ack", 8'h00, {7'h00, ack});
    u_sra_host_model.stopCond();
    wrTxn({8'h10}, 1'b1, 1'b0);
    rdChk({8'h05});
    rdChk({8'h05});
  endtask : sRamByte

  task automatic sRamBlock;
    wrTxn({8'h7E}, 1'b1, 1'b1);
    wrTxn({8'hA0, 8'h02, 8'hC3, 8'h3C}, 1'b1, 1'b1);
    wrTxn({8'h7E}, 1'b1, 1'b1);
    wrTxn({8'hA1}, 1'b1, 1'b0);
    rdChk({BLK_CNT, 8'hC3, 8'h3C, 8'h00, 8'h00});
  endtask : sRamBlock

  task automatic sNvPage;
    wrTxn({8'h81, 8'h3F}, 1'b1, 1'b1);
    wrTxn({8'hA2, 8'h3F}, 1'b1, 1'b1);
    wrTxn({8'h81}, 1'b0, 1'b1);
    waitIdle();
    wrTxn({8'h81, 8'h3F, 8'h5A}, 1'b1, 1'b1);
    wrTxn({8'h80}, 1'b0, 1'b1);
    waitIdle();
    wrTxn({8'h81, 8'h3E}, 1'b1, 1'b1);
    wrTxn({8'hA1}, 1'b1, 1'b0);
    rdChk({BLK_CNT, 8'hFF, 8'h5A, 8'h00, 8'h00});
    wrTxn({8'h80, 8'hFE}, 1'b1, 1'b1);
    wrTxn({8'hA2, 8'hFE}, 1'b1, 1'b1);
    waitIdle();
    wrTxn({8'hA1}, 1'b1, 1'b0);
    rdChk({BLK_CNT, 8'hFF, 8'hFF, 8'h00, 8'h00});
  endtask : sNvPage

  task automatic sNvBlock;
    int   s0;
    logic ack;
    wrTxn({8'h80, 8'h00}, 1'b1, 1'b1);
    wrTxn({8'hA2, 8'h00}, 1'b1, 1'b1);
    waitIdle();
    wrTxn({8'h80, 8'h1C}, 1'b1, 1'b1);
    s0 = u_sra_host_model.stretchSeen;
    // four bytes outrun the programmer, so the two-entry buffer must fill and stall the bus
    wrTxn({8'hA0, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44}, 1'b1, 1'b1);
    chk("clock stretch", 8'h01, {7'h00, u_sra_host_model.stretchSeen > s0});
    // queued bytes are still programming, so a read at a nonvolatile pointer is refused
    u_sra_host_model.startCond();
    u_sra_host_model.wrByte({DEV_ADDR, 1'b1}, ack);
    chk("busy read address ack", 8'h00, {7'h00, ack});
    u_sra_host_model.stopCond();
    waitIdle();
    wrTxn({8'h80, 8'h1C}, 1'b1, 1'b1);
    wrTxn({8'hA1}, 1'b1, 1'b0);
    rdChk({BLK_CNT, 8'h11, 8'h22, 8'h33, 8'h44});
    wrTxn({8'h80, 8'h1D}, 1'b1, 1'b0);
    rdChk({8'h22});
  endtask : sNvBlock

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    sys_rst   = 1'b1;
    slaveAddr = DEV_ADDR;
    repeat (4) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    repeat (2) @(posedge clk);
    sRamByte();
    sRamBlock();
    sNvPage();
    sNvBlock();
    endSim();
  end
endmodule : tb

bind sra_core sra_core_props #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_sra_core_props (
  .clk      (clk),
  .sys_rst  (sys_rst),
  .sclIn    (sclIn),
  .sclOut   (sclOut),
  .sclOe    (sclOe),
  .sdaIn    (sdaIn),
  .sdaOut   (sdaOut),
  .sdaOe    (sdaOe),
  .slaveAddr(slaveAddr),
  .nvBusy   (nvBusy)
);
